// file: verilog/wakeup_interrupt_ctrl.v
// Wake-up, sleep and interrupt dispatch controller with an APB register slave.
`timescale 1ns/1ns
// What this block does
// - No sleep wake from external pin or timer.
// - External event, interrupts off: flag, continue.
// - External event, interrupts on: flag, vector 0x08.
// - Port change ignored with both enables clear.
// - Asleep, interrupt only: flag set, stay asleep.
// - Asleep, wake only: wake, resume next instruction.
// - Asleep, both enables, interrupts off: wake, flag, continue.
// - Port change, interrupts on: flag, vector, wake first.
// - Running, port change, interrupts off: flag, continue.
// - Timer overflow enabled: flag, vector or continue.
// - Comparator change ignored with both enables clear.
// - Asleep, comparator interrupt only: flag, stay asleep.
// - Asleep, comparator wake only: wake, no flag.
// - Comparator, interrupts off: flag, continue, wake first.
// - Comparator, interrupts on: flag, vector, wake first.
// - Watchdog time-out resets core to 0x00.
// - Low voltage forces reset to normal mode.
// - Oscillator and timer stopped while asleep.
// - Sleep entry clears enabled watchdog, keeps counting.
// - Watchdog on at sleep drops change wake enables.
`include "wakeup_interrupt_ctrl_defs.vh"

// Overview.
// The block sits between the processor core, the event sources and the register bus.
// It keeps two modes, normal and sleep, and decides for every event what the core does.
// An event may set a pending flag, load the program counter, let the core continue,
// end sleep, or reset the core.
//
// Register bus.
// The slave answers with zero wait states, so pready is a constant high.
// Read data is loaded in the setup cycle and stands through the access cycle.
// A write takes effect at the edge that ends the access cycle.
// An unmapped address raises pslverr in the access cycle; such writes are dropped.
// The status word is read only, and writes to it are ignored without an error.
//
// Pending flags.
// The flag register is write one to clear.
// A hardware set in the same cycle as a software clear wins, so no event is lost.
// Flags never clear themselves, whether or not the event woke or vectored the core.
//
// Event inputs.
// Pins and the comparator come from outside the clock domain and pass three stages.
// A new level is taken only once stages two and three agree, which filters a glitch
// that lasts a single cycle.
// The synchronisers are preset to the idle level of each input, so that no false
// edge follows the release of reset.
// The external pin acts on its falling edge, the comparator on either edge, and a
// port change on any bit that moves.
// Timer overflow, watchdog time-out and the instruction pulses are one-cycle pulses
// on this clock and are used as they come.
//
// Normal mode.
// The wake enables are not looked at.
// Each enabled source sets its flag; with global interrupts on, the core is sent
// to the vector address, otherwise it simply goes on with the next instruction.
// A sleep instruction in the cycle of a vector is dropped, so that an interrupt is
// never parked behind sleep; the core may issue sleep again after the handler.
//
// Sleep mode.
// The external pin and the timer are ignored, since the timer does not count.
// A port or comparator change sets its flag when its interrupt enable is set.
// It ends sleep only when its wake enable is set.
// On waking, a newly set flag with global interrupts on sends the core to the
// vector; otherwise the core resumes after the sleep instruction.
// A comparator wake with its interrupt enable clear sets no flag.
//
// Resets.
// An enabled watchdog time-out or a rise of the low-voltage input resets the core
// to the reset address and returns the block to normal mode from either mode.
// Reset outranks every other answer in its cycle except the setting of an enabled flag, and clears the global enable.
// The status word records which of the two caused the last reset.
//
// Watchdog at sleep entry.
// With the watchdog enabled, entering sleep pulses the watchdog clear output and
// drops both change wake enables, so only reset or the watchdog can end sleep.
// The watchdog counter itself lives outside this block and keeps counting.
//
// Limitations.
// Oscillator start-up and reset hold times are the business of the clock and reset
// logic outside; the run outputs here are plain levels.
// This block's own clock must keep running in sleep, since it has to see the wake
// events; only the core's oscillator and the timer are stopped.
// An event arriving in the cycle of a reset sets its flag but gets no vector, which is harmless because the
// core restarts from the reset address anyway.

module wakeup_interrupt_ctrl #(
    parameter PORT_W = 8
) (
    input  wire              pclk,
    input  wire              presetn,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [7:0]        paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output wire              pready,
    output reg               pslverr,
    input  wire              external_irq_pin,
    input  wire [PORT_W-1:0] port_pins,
    input  wire              comparator_out,
    input  wire              low_voltage,
    input  wire              timer_overflow,
    input  wire              watchdog_timeout,
    input  wire              sleep_instr,
    input  wire              global_irq_on_instr,
    input  wire              global_irq_off_instr,
    output reg               osc_run,
    output reg               timer_run,
    output reg               watchdog_clear,
    output reg               pc_load,
    output reg  [7:0]        pc_target,
    output reg               resume_next,
    output reg               core_reset
);

    // One-hot mode codes; bit 0 is normal mode and bit 1 is sleep.
    localparam ST_RUN   = 2'b01;
    localparam ST_SLEEP = 2'b10;

    reg  [1:0]        state;
    reg  [7:0]        irq_en;
    reg  [7:0]        cmp_wdt;
    reg  [7:0]        wake_en;
    reg  [3:0]        flags;
    reg               global_ie;
    reg               wdt_cause;
    reg               lvr_cause;

    // Three-stage synchronisers; a value is taken once stages two and three agree.
    reg  [PORT_W-1:0] port_s1;
    reg  [PORT_W-1:0] port_s2;
    reg  [PORT_W-1:0] port_s3;
    reg  [PORT_W-1:0] port_filt;
    reg  [2:0]        misc_s1;
    reg  [2:0]        misc_s2;
    reg  [2:0]        misc_s3;
    reg  [2:0]        misc_filt;

    wire [PORT_W-1:0] next_port_filt;
    wire [2:0]        next_misc_filt;
    wire              ext_evt;
    wire              port_evt;
    wire              cmp_evt;
    wire              lvr_evt;

    wire              wr_en;
    wire              rd_setup;
    wire [3:0]        flag_clr;
    wire              is_run;
    wire              is_sleep;

    wire              en_tmr;
    wire              en_port_irq;
    wire              en_ext;
    wire              en_cmp_irq;
    wire              en_wdt;
    wire              en_port_wake;
    wire              en_cmp_wake;

    reg  [3:0]        flag_set;
    reg               do_vector;
    reg               do_resume;
    reg               do_wake;
    reg               do_reset;
    reg  [1:0]        next_state;

    function valid_addr;
        input [7:0] a;
        begin
            valid_addr = (a == `OFS_IRQ_EN) || (a == `OFS_CMP_WDT) ||
                         (a == `OFS_WAKE_EN) || (a == `OFS_FLAGS) ||
                         (a == `OFS_STATUS);
        end
    endfunction

    assign next_port_filt = (port_s2 & ~(port_s2 ^ port_s3)) |
                            (port_filt & (port_s2 ^ port_s3));
    assign next_misc_filt = (misc_s2 & ~(misc_s2 ^ misc_s3)) |
                            (misc_filt & (misc_s2 ^ misc_s3));

    // Bit 0 external pin, bit 1 comparator, bit 2 low voltage.
    assign ext_evt  = misc_filt[0] & ~next_misc_filt[0];
    assign cmp_evt  = misc_filt[1] ^ next_misc_filt[1];
    assign lvr_evt  = ~misc_filt[2] & next_misc_filt[2];
    assign port_evt = |(port_filt ^ next_port_filt);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_s1   <= {PORT_W{1'b0}};
            port_s2   <= {PORT_W{1'b0}};
            port_s3   <= {PORT_W{1'b0}};
            port_filt <= {PORT_W{1'b0}};
            misc_s1   <= 3'h3;
            misc_s2   <= 3'h3;
            misc_s3   <= 3'h3;
            misc_filt <= 3'h3;
        end else begin
            port_s1   <= port_pins;
            port_s2   <= port_s1;
            port_s3   <= port_s2;
            port_filt <= next_port_filt;
            misc_s1   <= {low_voltage, comparator_out, external_irq_pin};
            misc_s2   <= misc_s1;
            misc_s3   <= misc_s2;
            misc_filt <= next_misc_filt;
        end
    end

    // The registers are plain flip-flops, so every access finishes without waiting.
    // Read data is captured in the setup cycle; a write lands only in the access cycle.
    assign pready   = 1'b1;
    assign wr_en    = psel & penable & pwrite;
    assign rd_setup = psel & ~penable;
    assign flag_clr = (wr_en && paddr == `OFS_FLAGS) ? pwdata[3:0] : 4'h0;

    assign is_run       = state[0];
    assign is_sleep     = state[1];
    assign en_tmr       = irq_en[`BIT_TIMER_OVF_IRQ_EN];
    assign en_port_irq  = irq_en[`BIT_PORT_CHANGE_IRQ_EN];
    assign en_ext       = irq_en[`BIT_EXT_IRQ_EN];
    assign en_cmp_irq   = cmp_wdt[`BIT_COMPARATOR_IRQ_EN];
    assign en_wdt       = cmp_wdt[`BIT_WATCHDOG_EN];
    assign en_port_wake = wake_en[`BIT_PORT_CHANGE_WAKE_EN];
    assign en_cmp_wake  = wake_en[`BIT_COMPARATOR_WAKE_EN];

    // Event decode. Resets outrank everything but flag setting; a vector in the same cycle as a
    // sleep instruction wins so the interrupt is never parked behind sleep.
    always @* begin
        flag_set   = 4'h0;
        do_vector  = 1'b0;
        do_resume  = 1'b0;
        do_wake    = 1'b0;
        do_reset   = 1'b0;
        next_state = state;
        case (state)
            ST_RUN: begin
                if (ext_evt && en_ext) begin
                    flag_set[`BIT_EXT_IRQ0_FLAG] = 1'b1;
                end
                if (timer_overflow && en_tmr) begin
                    flag_set[`BIT_TIMER_OVF_FLAG] = 1'b1;
                end
                if (port_evt && en_port_irq) begin
                    flag_set[`BIT_PORT_CHANGE_FLAG] = 1'b1;
                end
                if (cmp_evt && en_cmp_irq) begin
                    flag_set[`BIT_COMPARATOR_FLAG] = 1'b1;
                end
                do_vector = global_ie && (|flag_set);
                if (sleep_instr && !do_vector) begin
                    next_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                // External pin and timer are not looked at here.
                if (port_evt && en_port_irq) begin
                    flag_set[`BIT_PORT_CHANGE_FLAG] = 1'b1;
                end
                if (cmp_evt && en_cmp_irq) begin
                    flag_set[`BIT_COMPARATOR_FLAG] = 1'b1;
                end
                do_wake = (port_evt && en_port_wake) ||
                          (cmp_evt && en_cmp_wake);
                if (do_wake) begin
                    next_state = ST_RUN;
                    if (global_ie && (|flag_set)) begin
                        do_vector = 1'b1;
                    end else begin
                        do_resume = 1'b1;
                    end
                end
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
        if ((watchdog_timeout && en_wdt) || lvr_evt) begin
            do_reset   = 1'b1;
            do_vector  = 1'b0;
            do_resume  = 1'b0;
            next_state = ST_RUN;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state          <= ST_RUN;
            irq_en         <= `RST_IRQ_EN;
            cmp_wdt        <= `RST_CMP_WDT;
            wake_en        <= `RST_WAKE_EN;
            flags          <= `RST_FLAGS;
            global_ie      <= 1'b0;
            wdt_cause      <= 1'b0;
            lvr_cause      <= 1'b0;
            osc_run        <= 1'b1;
            timer_run      <= 1'b1;
            watchdog_clear <= 1'b0;
            pc_load        <= 1'b0;
            pc_target      <= `ADDR_RESET;
            resume_next    <= 1'b0;
            core_reset     <= 1'b0;
            prdata         <= 32'h0000_0000;
            pslverr        <= 1'b0;
        end else begin
            state <= next_state;
            // A set in the same cycle as a software clear wins.
            flags <= (flags & ~flag_clr) | flag_set;

            if (do_reset) begin
                global_ie <= 1'b0;
            end else if (global_irq_on_instr) begin
                global_ie <= 1'b1;
            end else if (global_irq_off_instr) begin
                global_ie <= 1'b0;
            end

            if (wr_en && paddr == `OFS_IRQ_EN) begin
                irq_en <= pwdata[7:0];
            end
            if (wr_en && paddr == `OFS_CMP_WDT) begin
                cmp_wdt <= pwdata[7:0];
            end
            if (is_run && next_state == ST_SLEEP && en_wdt) begin
                wake_en[`BIT_PORT_CHANGE_WAKE_EN] <= 1'b0;
                wake_en[`BIT_COMPARATOR_WAKE_EN]  <= 1'b0;
            end else if (wr_en && paddr == `OFS_WAKE_EN) begin
                wake_en <= pwdata[7:0];
            end

            // The cause bits hold until the next reset, so software can read them at leisure.
            if (do_reset) begin
                wdt_cause <= ~lvr_evt;
                lvr_cause <= lvr_evt;
            end

            // Oscillator and timer follow the next state so they stop with sleep entry.
            osc_run        <= (next_state == ST_RUN);
            timer_run      <= (next_state == ST_RUN);
            watchdog_clear <= is_run && next_state == ST_SLEEP && en_wdt;
            pc_load        <= do_vector | do_reset;
            if (do_reset) begin
                pc_target <= `ADDR_RESET;
            end else if (do_vector) begin
                pc_target <= `ADDR_VECTOR;
            end
            resume_next    <= do_resume;
            core_reset     <= do_reset;

            // Capturing in the setup cycle lets read data stand for the whole access cycle.
            // The value read is the one that stood at the setup edge.
            if (rd_setup) begin
                pslverr <= ~valid_addr(paddr);
                case (paddr)
                    `OFS_IRQ_EN:  prdata <= {24'h000000, irq_en};
                    `OFS_CMP_WDT: prdata <= {24'h000000, cmp_wdt};
                    `OFS_WAKE_EN: prdata <= {24'h000000, wake_en};
                    `OFS_FLAGS:   prdata <= {28'h0000000, flags};
                    `OFS_STATUS:  prdata <= {28'h0000000, lvr_cause, wdt_cause,
                                             global_ie, is_sleep};
                    default:      prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule // wakeup_interrupt_ctrl

// file: verilog/wakeup_interrupt_ctrl_defs.vh
// Register map, field positions, reset values and addresses of the wake-up and interrupt block.
`ifndef WAKEUP_INTERRUPT_CTRL_DEFS_VH
`define WAKEUP_INTERRUPT_CTRL_DEFS_VH

// Register byte offsets.
`define OFS_IRQ_EN          8'h00
`define OFS_CMP_WDT         8'h04
`define OFS_WAKE_EN         8'h08
`define OFS_FLAGS           8'h0c
`define OFS_STATUS          8'h10

// Interrupt enable register fields.
`define BIT_TIMER_OVF_IRQ_EN   0
`define BIT_PORT_CHANGE_IRQ_EN 1
`define BIT_EXT_IRQ_EN         2

// Comparator and watchdog control fields.
`define BIT_COMPARATOR_IRQ_EN  0
`define BIT_WATCHDOG_EN        7

// Wake enable fields.
`define BIT_COMPARATOR_WAKE_EN  2
`define BIT_PORT_CHANGE_WAKE_EN 4

// Pending flag fields, write one to clear.
`define BIT_TIMER_OVF_FLAG   0
`define BIT_PORT_CHANGE_FLAG 1
`define BIT_EXT_IRQ0_FLAG    2
`define BIT_COMPARATOR_FLAG  3

// Status fields, read only.
`define BIT_ST_ASLEEP     0
`define BIT_ST_GLOBAL_IE  1
`define BIT_ST_WDT_CAUSE  2
`define BIT_ST_LVR_CAUSE  3

// Reset values.
`define RST_IRQ_EN   8'h00
`define RST_CMP_WDT  8'h00
`define RST_WAKE_EN  8'h00
`define RST_FLAGS    4'h0

// Program addresses handed to the core.
`define ADDR_RESET   8'h00
`define ADDR_VECTOR  8'h08

`endif

// file: verification/wic_properties.sv
// Port-level assertions for the wake-up and interrupt controller.
`timescale 1ns/1ns
module wic_properties (
    input wire       pclk,
    input wire       presetn,
    input wire       psel,
    input wire       penable,
    input wire [7:0] paddr,
    input wire       pready,
    input wire       pslverr,
    input wire       osc_run,
    input wire       timer_run,
    input wire       watchdog_clear,
    input wire       pc_load,
    input wire       resume_next,
    input wire       core_reset,
    input wire       timer_overflow,
    input wire       sleep_instr
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_PREADY: assert property (psel |-> pready)
        else $error("pready low in a transfer");
    AST_SLVERR: assert property (psel && penable && paddr > 8'h10 |-> pslverr)
        else $error("unmapped access not refused");
    AST_MAPPED: assert property (psel && penable && paddr < 8'h11 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped access refused");
    AST_OSC_TIMER: assert property (osc_run == timer_run)
        else $error("oscillator and timer run differ");
    AST_OSC_FALL: assert property ($fell(osc_run) |-> $past(sleep_instr))
        else $error("sleep entered without sleep instruction");
    AST_TIMER_SLEEP: assert property (!osc_run && timer_overflow |=> !pc_load && !resume_next)
        else $error("timer overflow acted in sleep");
    AST_EXCL: assert property (!(pc_load && resume_next))
        else $error("vector and continue together");
    AST_RESET_RUN: assert property (core_reset |-> osc_run && timer_run)
        else $error("reset did not return to normal mode");
    AST_RESUME_RUN: assert property (resume_next |-> osc_run)
        else $error("continue while still asleep");
    AST_WDCLR: assert property (watchdog_clear |-> $past(sleep_instr) ##1 !watchdog_clear)
        else $error("watchdog clear not a sleep-entry pulse");
endmodule // wic_properties

bind wakeup_interrupt_ctrl wic_properties chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .osc_run(osc_run), .timer_run(timer_run),
    .watchdog_clear(watchdog_clear), .pc_load(pc_load), .resume_next(resume_next),
    .core_reset(core_reset), .timer_overflow(timer_overflow), .sleep_instr(sleep_instr)
);

// file: verification/core_model.sv
// Core model: issues instruction and event pulses and records the controller's answers.
`timescale 1ns/1ns
module core_model (
    input  wire       pclk,
    input  wire       clr,
    input  wire       pc_load,
    input  wire [7:0] pc_target,
    input  wire       resume_next,
    input  wire       core_reset,
    input  wire       watchdog_clear,
    output reg  [4:0] pulse,
    output reg  [3:0] seen
);
    initial pulse = 5'h00;
    initial seen = 4'h0;
    // Pulse index: 0 sleep, 1 global on, 2 global off, 3 timer overflow, 4 watchdog.
    task fire(input integer n);
        begin
            @(posedge pclk);
            pulse[n] <= 1'b1;
            @(posedge pclk);
            pulse <= 5'h00;
        end
    endtask
    // Answers are sticky so a one-cycle pulse is never missed between checks.
    always @(posedge pclk) begin
        if (clr)
            seen <= 4'h0;
        else
            seen <= seen | {watchdog_clear, core_reset, resume_next,
                            pc_load && pc_target == 8'h08};
    end
endmodule // core_model

// file: verification/testbench.sv
// Self-checking bench for the wake-up and interrupt controller.
`timescale 1ns/1ns
`define CHK(g, e) begin compares = compares + 1; if ((g) !== (e)) begin fail_count = fail_count + 1; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    reg         pclk, presetn, psel, penable, pwrite, ext_pin, comp, lv, clr, err;
    reg  [7:0]  paddr, port;
    reg  [31:0] pwdata, rdv;
    wire [31:0] prdata;
    wire        pready, pslverr, osc_run, timer_run, wd_clr, pc_load, resume, c_rst;
    wire [7:0]  pc_target;
    wire [4:0]  pulse;
    wire [3:0]  seen;
    integer     fail_count, compares, cyc, i;
    wakeup_interrupt_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .external_irq_pin(ext_pin),
        .port_pins(port), .comparator_out(comp), .low_voltage(lv),
        .timer_overflow(pulse[3]), .watchdog_timeout(pulse[4]), .sleep_instr(pulse[0]),
        .global_irq_on_instr(pulse[1]), .global_irq_off_instr(pulse[2]),
        .osc_run(osc_run), .timer_run(timer_run), .watchdog_clear(wd_clr),
        .pc_load(pc_load), .pc_target(pc_target), .resume_next(resume), .core_reset(c_rst));
    core_model core (.pclk(pclk), .clr(clr), .pc_load(pc_load), .pc_target(pc_target),
        .resume_next(resume), .core_reset(c_rst), .watchdog_clear(wd_clr),
        .pulse(pulse), .seen(seen));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Each transfer starts one edge after the last one ended, so psel is never assigned twice.
    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) @(posedge pclk);
            rdv = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    // Answers may take up to five edges after a pin moves, so eight gives margin.
    task expect_ev(input [3:0] e, input o);
        begin
            repeat (8) @(posedge pclk);
            `CHK(seen, e)
            `CHK(osc_run, o)
            clr <= 1'b1;
            @(posedge pclk);
            clr <= 1'b0;
        end
    endtask
    task flags(input [31:0] e);
        begin
            apb(1'b0, 8'h0c, 32'h0);
            `CHK(rdv, e)
            apb(1'b1, 8'h0c, 32'hf);
        end
    endtask
    task conclude;
        begin
            $display("compares=%0d fail_count=%0d", compares, fail_count);
            if (fail_count == 0 && compares > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    always @(posedge pclk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            fail_count = fail_count + 1;
            conclude;
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, port, lv, clr, cyc} = 0;
        {ext_pin, comp} = 2'b11;
        fail_count = 0;
        compares = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (i = 0; i < 4; i = i + 1) begin
            apb(1'b0, i * 4, 32'h0);
            `CHK(rdv, 32'h0)
        end
        apb(1'b0, 8'h14, 32'h0);
        `CHK({err, rdv}, 33'h100000000)
        port <= 8'h01;
        comp <= 1'b0;
        expect_ev(4'h0, 1'b1);
        flags(32'h0);
        apb(1'b1, 8'h00, 32'h4);
        ext_pin <= 1'b0;
        expect_ev(4'h0, 1'b1);
        ext_pin <= 1'b1;
        repeat (20) @(posedge pclk);
        flags(32'h4);
        core.fire(1);
        ext_pin <= 1'b0;
        expect_ev(4'h1, 1'b1);
        ext_pin <= 1'b1;
        apb(1'b1, 8'h00, 32'h1);
        core.fire(3);
        expect_ev(4'h1, 1'b1);
        core.fire(2);
        core.fire(3);
        expect_ev(4'h0, 1'b1);
        flags(32'h5);
        apb(1'b1, 8'h00, 32'h7);
        core.fire(0);
        ext_pin <= 1'b0;
        core.fire(3);
        expect_ev(4'h0, 1'b0);
        ext_pin <= 1'b1;
        flags(32'h0);
        port <= 8'h03;
        expect_ev(4'h0, 1'b0);
        flags(32'h2);
        apb(1'b1, 8'h08, 32'h10);
        port <= 8'h00;
        expect_ev(4'h2, 1'b1);
        flags(32'h2);
        core.fire(1);
        core.fire(0);
        port <= 8'h01;
        expect_ev(4'h1, 1'b1);
        core.fire(2);
        port <= 8'h00;
        expect_ev(4'h0, 1'b1);
        flags(32'h2);
        apb(1'b1, 8'h00, 32'h0);
        core.fire(0);
        port <= 8'h01;
        expect_ev(4'h2, 1'b1);
        apb(1'b1, 8'h08, 32'h4);
        core.fire(0);
        comp <= 1'b1;
        expect_ev(4'h2, 1'b1);
        flags(32'h0);
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h04, 32'h1);
        core.fire(0);
        comp <= 1'b0;
        expect_ev(4'h0, 1'b0);
        flags(32'h8);
        apb(1'b1, 8'h08, 32'h4);
        comp <= 1'b1;
        expect_ev(4'h2, 1'b1);
        flags(32'h8);
        core.fire(1);
        comp <= 1'b0;
        expect_ev(4'h1, 1'b1);
        flags(32'h8);
        apb(1'b1, 8'h08, 32'h14);
        apb(1'b1, 8'h04, 32'h80);
        core.fire(0);
        expect_ev(4'h8, 1'b0);
        apb(1'b0, 8'h08, 32'h0);
        `CHK(rdv, 32'h0)
        core.fire(4);
        expect_ev(4'h4, 1'b1);
        apb(1'b0, 8'h10, 32'h0);
        `CHK(rdv & 32'hd, 32'h4)
        lv <= 1'b1;
        expect_ev(4'h4, 1'b1);
        conclude;
    end
endmodule // testbench
